/* tls_pkg.sv */
// package for the tape load sequencer: constants, modes and carriers
package tls_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned DEBOUNCE_US = 5000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned GUARD_MS = 2000;
  localparam int unsigned GUARD_CYC = GUARD_MS * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_MS = 1000;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned FAULT_MS = 3000;
  localparam int unsigned FAULT_CYC = FAULT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 32;

  // ---------------------------------------------------------------
  // register bus map
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int unsigned CTRL_VACUUM_BIT = 0;
  localparam int unsigned CTRL_TWO_PRESS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TLS_BTN_IDLE = 2'b00,
    TLS_BTN_HELD = 2'b01
  } tls_btn_t;

  typedef struct packed {
    logic load_button;
    logic arms_down_seen;
    logic arms_up_seen;
    logic interlock_a;
    logic interlock_b;
    logic vacuum_loops_ok;
    logic bot_marker_seen;
    logic tape_absent;
    logic loop_slack;
  } tls_sw_t;

  localparam int unsigned SW_W = 9;

  typedef struct packed {
    logic retract_relay;
    logic servo_connect_relay;
    logic reel_torque_n;
    logic forward_request;
    logic bot_stop_strobe;
    logic load_fault;
    logic load_indicator;
  } tls_out_t;

endpackage : tls_pkg

/* tls_sequencer.sv */
// tape load sequencer: synchronised switches, load flags, timers, relays, apb
`timescale 1ns/1ps

module tls_sequencer
  import tls_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
  parameter int unsigned GUARD = GUARD_CYC,
  parameter int unsigned SETTLE = SETTLE_CYC,
  parameter int unsigned FAULT = FAULT_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic power_good_n,
  input wire tls_sw_t sw_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tls_out_t act
);

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  // every interval counter compares the same way, so the end point is defined once
  function automatic logic tls_reached(input logic [CNT_W-1:0] cnt, input int unsigned limit);
    tls_reached = cnt >= CNT_W'(limit);
  endfunction : tls_reached

  // only the two words of the map answer without an error
  function automatic logic tls_mapped(input logic [11:0] addr);
    tls_mapped = addr == CTRL_OFS || addr == STAT_OFS;
  endfunction : tls_mapped

  // ---------------------------------------------------------------
  // input synchronisers and debounce
  // ---------------------------------------------------------------
  logic [SW_W-1:0] s1, s2, s3, sw_db;
  logic [SW_W-1:0][CNT_W-1:0] db_cnt;
  logic pg1, pg2, pg3, pg_ok;
  tls_sw_t sw;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pg1 <= 1'b0;
      pg2 <= 1'b0;
      pg3 <= 1'b0;
    end else begin
      // the first stage may settle late, so only the second and third are ever compared
      s1 <= sw_in;
      s2 <= s1;
      s3 <= s2;
      // power_good_n high means supplies are good; low holds every load flag in init
      pg1 <= power_good_n;
      pg2 <= pg1;
      pg3 <= pg2;
    end
  end

  // power good counts once second and third stages agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pg_ok <= 1'b0;
    end else if (pg2 == pg3) begin
      pg_ok <= pg3;
    end
  end

  // a switch change must hold steady for the debounce window before it counts
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sw_db <= '0;
      db_cnt <= '0;
    end else begin
      for (int i = 0; i < SW_W; i++) begin
        // a glitch that flips back before the window ends restarts the count
        if (s2[i] != s3[i] || s3[i] == sw_db[i]) begin
          db_cnt[i] <= '0;
        end else if (tls_reached(db_cnt[i], DEBOUNCE)) begin
          sw_db[i] <= s3[i];
          db_cnt[i] <= '0;
        end else begin
          db_cnt[i] <= db_cnt[i] + 1'b1;
        end
      end
    end
  end

  assign sw = tls_sw_t'(sw_db);

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  logic [1:0] ctrl;
  logic vacuum, two_press;
  assign vacuum = ctrl[CTRL_VACUUM_BIT];
  assign two_press = ctrl[CTRL_TWO_PRESS_BIT];

  // ---------------------------------------------------------------
  // pushbutton press-release pulse
  // ---------------------------------------------------------------
  tls_btn_t btn;
  logic press_pulse;
  logic init;
  assign init = ~pg_ok;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      btn <= TLS_BTN_IDLE;
      press_pulse <= 1'b0;
    end else begin
      press_pulse <= 1'b0;
      unique case (btn)
        TLS_BTN_IDLE: begin
          if (sw.load_button) begin
            btn <= TLS_BTN_HELD;
          end
        end
        TLS_BTN_HELD: begin
          if (!sw.load_button) begin
            btn <= TLS_BTN_IDLE;
            // the pulse follows the release, so a held button cannot start two loads
            press_pulse <= pg_ok;
          end
        end
        default: begin
          btn <= TLS_BTN_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencing flags
  // ---------------------------------------------------------------
  logic first_phase_flag, seek_bot_flag, loaded_flag, guard_timeout;
  logic interlock_made, entry_confirm, settle_ready, torque_on;
  logic fault_expired, guard_expired, second_phase_holdoff, bot_hit;
  logic [CNT_W-1:0] guard_cnt, settle_cnt, fault_cnt;
  logic guard_run;

  // the relay is part of the interlock: closed switches alone prove nothing
  assign interlock_made = act.servo_connect_relay & sw.interlock_a & sw.interlock_b;
  // swing-arm units settle at once, vacuum units after the load delay
  assign settle_ready = vacuum ? (first_phase_flag && tls_reached(settle_cnt, SETTLE)) : 1'b1;
  // torque only while threading; once interlocked the servos take over
  assign torque_on = first_phase_flag & ~interlock_made & settle_ready;
  assign entry_confirm = first_phase_flag & (vacuum ? sw.vacuum_loops_ok : sw.arms_down_seen);
  assign guard_expired = guard_run && tls_reached(guard_cnt, GUARD);
  assign fault_expired = torque_on && tls_reached(fault_cnt, FAULT);
  // two-press: the seek flag is held clear until the servos hold the loops
  assign second_phase_holdoff = two_press & ~interlock_made;
  assign bot_hit = seek_bot_flag & sw.bot_marker_seen;

  // aborts win over a press in the same cycle so a dying load cannot re-arm
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_phase_flag <= 1'b0;
    end else if (init || guard_timeout || fault_expired) begin
      first_phase_flag <= 1'b0;
    end else if (press_pulse && !loaded_flag && !first_phase_flag) begin
      first_phase_flag <= 1'b1;
    end
  end

  // last cycle's first phase, to see it fall
  logic fp_prev;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fp_prev <= 1'b0;
    end else begin
      fp_prev <= first_phase_flag;
    end
  end

  // ---------------------------------------------------------------
  // seek-to-marker phase and loaded flag
  // ---------------------------------------------------------------
  // two-press: the second pulse counts only after the first phase has ended
  // single press: the fall of the first phase starts the seek by itself
  logic start_seek;
  assign start_seek = !loaded_flag && (two_press
    ? (press_pulse && !first_phase_flag && interlock_made && fp_prev == first_phase_flag)
    : (fp_prev && !first_phase_flag && !init));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seek_bot_flag <= 1'b0;
      loaded_flag <= 1'b0;
    end else if (init) begin
      seek_bot_flag <= 1'b0;
      loaded_flag <= 1'b0;
    end else begin
      // clears take priority: the marker stops motion before anything re-arms it
      if (bot_hit || second_phase_holdoff && !start_seek) begin
        seek_bot_flag <= 1'b0;
      end else if (start_seek) begin
        seek_bot_flag <= 1'b1;
      end
      if (start_seek) begin
        loaded_flag <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // guard one-shot, load delay and fault timer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      guard_run <= 1'b0;
      guard_cnt <= '0;
      guard_timeout <= 1'b0;
    end else if (init) begin
      guard_run <= 1'b0;
      guard_cnt <= '0;
      guard_timeout <= 1'b0;
    end else begin
      guard_timeout <= 1'b0;
      // one shot per entry: a new run needs the first phase armed again
      if (entry_confirm && !guard_run && !guard_timeout && first_phase_flag) begin
        guard_run <= 1'b1;
        guard_cnt <= '0;
      end else if (guard_expired) begin
        guard_run <= 1'b0;
        guard_timeout <= 1'b1;
      end else if (guard_run) begin
        guard_cnt <= guard_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt <= '0;
    end else if (!first_phase_flag) begin
      settle_cnt <= '0;
    end else if (!tls_reached(settle_cnt, SETTLE)) begin
      // the count parks at the limit so settle-ready holds for the rest of the first phase
      settle_cnt <= settle_cnt + 1'b1;
    end
  end

  // the fault stays visible until the next press so the operator sees why it stopped
  logic fault_latch;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fault_cnt <= '0;
      fault_latch <= 1'b0;
    end else if (init) begin
      fault_cnt <= '0;
      fault_latch <= 1'b0;
    end else begin
      if (!torque_on || fault_expired) begin
        fault_cnt <= '0;
      end else begin
        fault_cnt <= fault_cnt + 1'b1;
      end
      if (fault_expired) begin
        fault_latch <= 1'b1;
      end else if (press_pulse) begin
        fault_latch <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // relay and output registers
  // ---------------------------------------------------------------
  logic next_retract;
  // retract/vacuum relay: swing arms down, vacuum motor, or arms home when untapped
  always_comb begin
    next_retract = 1'b0;
    if (vacuum) begin
      // the same relay starts the vacuum motor the moment loading begins
      next_retract = first_phase_flag;
    end else begin
      // arms run down until the stop switch closes, then the relay lets go
      next_retract = first_phase_flag && !sw.arms_down_seen;
      // an empty path with the arms off the load stop drives them home
      if (sw.tape_absent && sw.loop_slack && !sw.arms_up_seen) begin
        next_retract = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      act <= '0;
      act.reel_torque_n <= 1'b1;
    end else if (init) begin
      act <= '0;
      act.reel_torque_n <= 1'b1;
    end else begin
      // every output is a register so relay drivers never see decode glitches
      act.retract_relay <= next_retract;
      act.servo_connect_relay <= (entry_confirm && !guard_timeout)
        || (act.servo_connect_relay && sw.interlock_a && sw.interlock_b);
      act.reel_torque_n <= ~torque_on;
      act.forward_request <= seek_bot_flag && !bot_hit;
      act.bot_stop_strobe <= bot_hit;
      act.load_fault <= fault_latch | fault_expired;
      act.load_indicator <= loaded_flag;
    end
  end

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  // status word, low bit first: spare, power good, interlock, first phase,
  // seek, loaded, fault latch, guard running, settle ready
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      CTRL_OFS: next_rdata = {30'h0, ctrl};
      STAT_OFS: next_rdata = {23'h0, settle_ready, guard_run, fault_latch, loaded_flag,
                              seek_bot_flag, first_phase_flag, interlock_made, pg_ok, 1'b0};
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // no wait state: the answer always stands in the first access cycle
      pready <= psel && !penable;
      pslverr <= psel && !penable && !tls_mapped(paddr);
      prdata <= (psel && !penable && !pwrite) ? next_rdata : '0;
    end
  end

  // mode changes mid-load are allowed but will confuse the sequence; set before loading
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
      ctrl <= pwdata[1:0];
    end
  end

endmodule : tls_sequencer

/* tls_sequencer_sva.sv */
// assertion checker for the tape load sequencer ports
`timescale 1ns/1ps
module tls_sequencer_sva
  import tls_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire tls_out_t act
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // bus and sequence checks
  // ---------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    s_setup ##0 (paddr != CTRL_OFS && paddr != STAT_OFS);
  endsequence
  sequence s_good;
    s_setup ##0 (paddr == CTRL_OFS || paddr == STAT_OFS);
  endsequence
  a_apb_answer: assert property (s_setup |=> pready)
    else $error("apb answer missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (s_bad |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (s_good |=> !pslverr)
    else $error("mapped access refused");
  a_strobe_single: assert property (act.bot_stop_strobe |=> !act.bot_stop_strobe)
    else $error("stop strobe too long");
  a_strobe_stops: assert property (act.bot_stop_strobe |-> ##[1:2] !act.forward_request)
    else $error("motion not stopped");
  a_forward_loaded: assert property (act.forward_request |-> act.load_indicator)
    else $error("forward without loaded");
  a_fault_abort: assert property ($rose(act.load_fault) |-> ##[0:3] act.reel_torque_n)
    else $error("fault did not abort");
endmodule : tls_sequencer_sva

bind tls_sequencer tls_sequencer_sva tls_sequencer_sva_inst (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .act(act));

/* tls_deck_model.sv */
// model of the deck: button, arm switches, interlocks and tape marker
`timescale 1ns/1ps
module tls_deck_model
  import tls_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire tls_out_t act,
  input wire logic press,
  input wire logic loops_en,
  input wire logic vac,
  input wire logic bot,
  input wire logic untape,
  output tls_sw_t sw
);
  logic [4:0] arm_cnt;
  logic down;
  // ---------------------------------------------------------------
  // arms travel only while the retract motor runs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      arm_cnt <= 5'h00;
      down <= 1'b0;
    end else if (act.retract_relay && !vac && !untape && !down) begin
      arm_cnt <= arm_cnt + 5'h01;
      down <= (arm_cnt == 5'h13);
    end else if (act.retract_relay && !vac && untape && down) begin
      // with no tape threaded the motor swings the arms back to the load stop
      arm_cnt <= arm_cnt - 5'h01;
      down <= (arm_cnt != 5'h01);
    end
  end
  always_comb begin
    sw = '0;
    sw.load_button = press;
    sw.arms_down_seen = down;
    sw.arms_up_seen = !down;
    // loops only settle once servos hold them
    sw.interlock_a = act.servo_connect_relay && loops_en;
    sw.interlock_b = act.servo_connect_relay && loops_en;
    sw.vacuum_loops_ok = vac && act.retract_relay && loops_en;
    sw.bot_marker_seen = bot;
    sw.tape_absent = untape;
    sw.loop_slack = untape;
  end
endmodule : tls_deck_model

/* tls_sequencer_test.sv */
// self-checking bench for the tape load sequencer
`timescale 1ns/1ps
module tls_sequencer_test
  import tls_pkg::*;
;
  localparam int RET = 6, SRV = 5, TRQ = 4, FWD = 3, STB = 2, FLT = 1, IND = 0;
  logic ref_clk, nrst, power_good_n, psel, penable, pwrite, pready, pslverr, er;
  logic press, loops_en, vac, bot, untape;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  tls_sw_t sw_in;
  tls_out_t act;
  int error_cnt, compares;
  tls_sequencer #(.DEBOUNCE(2), .GUARD(50), .SETTLE(10), .FAULT(60)) tls_sequencer_inst (.ref_clk(ref_clk),
    .nrst(nrst), .power_good_n(power_good_n), .sw_in(sw_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .act(act));
  tls_deck_model tls_deck_model_inst (.ref_clk(ref_clk), .nrst(nrst), .act(act), .press(press),
    .loops_en(loops_en), .vac(vac), .bot(bot), .untape(untape), .sw(sw_in));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("wrong value pready exp 1 seen %b", pready);
      end_of_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task wait_act(input int b, input logic v);
    int n;
    n = 0;
    while (act[b] !== v && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    compares++;
    if (n >= 400) begin
      error_cnt++;
      $display("wrong value act[%0d] exp %b seen %b", b, v, act[b]);
      end_of_test;
    end
  endtask : wait_act
  task push;
    press <= 1'b1;
    repeat (10) @(posedge ref_clk);
    press <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask : push
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    power_good_n = 1'b0;
    {psel, penable, pwrite, press, loops_en, vac, bot, untape} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    error_cnt = 0;
    compares = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    power_good_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'hFFFFFFFF);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl bits", rd, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0);
    $display("test registers done");
    push;
    wait_act(RET, 1'b1);
    wait_act(TRQ, 1'b0);
    wait_act(RET, 1'b0);
    wait_act(SRV, 1'b1);
    loops_en <= 1'b1;
    wait_act(TRQ, 1'b1);
    chk("no fault arm", act[FLT], 32'h0);
    wait_act(FWD, 1'b1);
    chk("loaded", act[IND], 32'h1);
    bot <= 1'b1;
    wait_act(STB, 1'b1);
    wait_act(FWD, 1'b0);
    chk("indicator", act[IND], 32'h1);
    chk("servo held", act[SRV], 32'h1);
    loops_en <= 1'b0;
    bot <= 1'b0;
    wait_act(SRV, 1'b0);
    untape <= 1'b1;
    wait_act(RET, 1'b1);
    wait_act(RET, 1'b0);
    untape <= 1'b0;
    $display("test swing arm done");
    apb(1'b1, CTRL_OFS, 32'h3);
    power_good_n <= 1'b0;
    wait_act(IND, 1'b0);
    chk("init outputs", act, 32'h10);
    power_good_n <= 1'b1;
    vac <= 1'b1;
    repeat (8) @(posedge ref_clk);
    push;
    wait_act(RET, 1'b1);
    chk("settle wait", act[TRQ], 32'h1);
    wait_act(TRQ, 1'b0);
    wait_act(FLT, 1'b1);
    wait_act(RET, 1'b0);
    loops_en <= 1'b1;
    push;
    wait_act(SRV, 1'b1);
    wait_act(FLT, 1'b0);
    repeat (80) @(posedge ref_clk);
    chk("no seek yet", act[FWD], 32'h0);
    chk("no fault", act[FLT], 32'h0);
    push;
    wait_act(FWD, 1'b1);
    chk("loaded 2", act[IND], 32'h1);
    bot <= 1'b1;
    wait_act(FWD, 1'b0);
    $display("test vacuum done");
    end_of_test;
  end
endmodule : tls_sequencer_test
